// ==== rtl/bcr_brake_reg.sv ====
// What this block does
// RULE1 - bit 9 turns slam mode on when 1, off when 0 (default)
// RULE2 - bit 10 set disables first low-side control during slam mode
// RULE3 - bits 11 and 12 do the same for second and third low-side outputs
// RULE4 - bit 8 picks brake drain-source threshold: 0 is 0.8 V, 1 is 0.22 V
// RULE5 - bit 7 picks brake blank time: 0 is 7 us, 1 is 11 us (default)
// RULE6 - bit 6 enables parking brake; reset value 0
// RULE7 - bit 5 enables overvoltage brake; reset value 1
// RULE8 - host writes zeros to reserved writable bits 4:3
// RULE9 - bits 2:0 pick overvoltage brake threshold, 27 V plus one volt per code
// RULE10 - bits 15:13 read zero and ignore writes
// RULE11 - power-on or soft reset loads 0x00A0
// RULE12 - restart reset clears bits 15:13 and 4:3, keeps the rest
// RULE13 - outputs are static levels effective right after the write completes
`timescale 1ns/100ps
`default_nettype none

module bcr_brake_reg (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic soft_reset,
    input wire logic restart_reset,
    input wire bcr_pkg::bcr_req_t req,
    output var bcr_pkg::bcr_rsp_t rsp,
    output var bcr_pkg::bcr_cfg_t cfg
);
    import bcr_pkg::*;

    bcr_state_t state;
    bcr_state_t next_state;

    function automatic logic [BCR_DATA_W-1:0] read_view(input logic [BCR_DATA_W-1:0] r);
        read_view = r & BCR_STORE_MASK; // RULE10
    endfunction

    logic hit;
    assign hit = (req.addr == BCR_BRAKE_ADDR);

    always_comb begin
        next_state = state;
        next_state.rsp.valid = req.wr | req.rd;
        next_state.rsp.hit = (req.wr | req.rd) & hit;
        next_state.rsp.rdata = '0;
        if (req.rd && hit) begin
            next_state.rsp.rdata = read_view(state.brake); // RULE10
        end
        // soft reset has priority over restart and over a write
        if (soft_reset) begin
            next_state.brake = BCR_BRAKE_RESET; // RULE11
        end else if (restart_reset) begin
            next_state.brake = state.brake & BCR_RESTART_KEEP; // RULE12
        end else if (req.wr && hit) begin
            // reserved bits 4:3 are stored as written; host keeps them zero
            next_state.brake = req.wdata & BCR_STORE_MASK; // RULE10 RULE8
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state.brake <= BCR_BRAKE_RESET; // RULE11
            state.rsp <= '0;
        end else begin
            state <= next_state;
        end
    end

    assign rsp = state.rsp;

    // straight from the register, so a write is live on the next edge
    always_comb begin
        cfg.slam_enable = state.brake[BCR_SLAM_BIT]; // RULE1 RULE13
        cfg.slam_lowside1_off = state.brake[BCR_LS1_OFF_BIT]; // RULE2
        cfg.slam_lowside2_off = state.brake[BCR_LS2_OFF_BIT]; // RULE3
        cfg.slam_lowside3_off = state.brake[BCR_LS3_OFF_BIT]; // RULE3
        cfg.brake_drain_source_threshold_sel = state.brake[BCR_VDS_BIT]; // RULE4
        cfg.brake_blank_time_sel = state.brake[BCR_BLANK_BIT]; // RULE5
        cfg.parking_brake_enable = state.brake[BCR_PARK_EN_BIT]; // RULE6
        cfg.overvoltage_brake_enable = state.brake[BCR_OV_EN_BIT]; // RULE7
        cfg.overvoltage_brake_threshold = state.brake[BCR_THRESH_MSB:BCR_THRESH_LSB]; // RULE9
    end

    // a write that lands; either reset wins over it
    logic wr_take;
    assign wr_take = req.wr && hit && !soft_reset && !restart_reset;

    property p_write_takes;
        @(posedge clk) disable iff (!rst_n)
        wr_take
        |=>
        (state.brake == ($past(req.wdata) & BCR_STORE_MASK));
    endproperty
    a_write_takes: assert property (p_write_takes) else $error("write not stored"); // RULE13

    property p_slam_level;
        @(posedge clk) disable iff (!rst_n)
        wr_take
        |=>
        (cfg.slam_enable == $past(req.wdata[BCR_SLAM_BIT]));
    endproperty
    a_slam_level: assert property (p_slam_level) else $error("slam level wrong"); // RULE1

    property p_ls_off;
        @(posedge clk) disable iff (!rst_n)
        wr_take
        |=>
        ({cfg.slam_lowside3_off, cfg.slam_lowside2_off, cfg.slam_lowside1_off} ==
         $past(req.wdata[BCR_LS3_OFF_BIT:BCR_LS1_OFF_BIT]));
    endproperty
    a_ls_off: assert property (p_ls_off) else $error("low-side disable wrong"); // RULE2 RULE3

    property p_sel_bits;
        @(posedge clk) disable iff (!rst_n)
        wr_take
        |=>
        (cfg.brake_drain_source_threshold_sel == $past(req.wdata[BCR_VDS_BIT])) &&
        (cfg.brake_blank_time_sel == $past(req.wdata[BCR_BLANK_BIT]));
    endproperty
    a_sel_bits: assert property (p_sel_bits) else $error("threshold or blank select wrong"); // RULE4 RULE5

    property p_enables;
        @(posedge clk) disable iff (!rst_n)
        wr_take
        |=>
        (cfg.parking_brake_enable == $past(req.wdata[BCR_PARK_EN_BIT])) &&
        (cfg.overvoltage_brake_enable == $past(req.wdata[BCR_OV_EN_BIT]));
    endproperty
    a_enables: assert property (p_enables) else $error("brake enables wrong"); // RULE6 RULE7

    property p_thresh;
        @(posedge clk) disable iff (!rst_n)
        wr_take
        |=>
        (cfg.overvoltage_brake_threshold == $past(req.wdata[BCR_THRESH_MSB:BCR_THRESH_LSB]));
    endproperty
    a_thresh: assert property (p_thresh) else $error("threshold code wrong"); // RULE9

    // read data is the word from before any write on the same edge
    property p_rsv_zero;
        @(posedge clk) disable iff (!rst_n)
        (req.rd && hit)
        |=>
        (rsp.valid && rsp.hit) &&
        ((rsp.rdata & ~BCR_STORE_MASK) == '0) &&
        (rsp.rdata == ($past(state.brake) & BCR_STORE_MASK));
    endproperty
    a_rsv_zero: assert property (p_rsv_zero) else $error("read data wrong"); // RULE10

    property p_soft;
        @(posedge clk) disable iff (!rst_n)
        soft_reset
        |=>
        (state.brake == BCR_BRAKE_RESET) &&
        cfg.overvoltage_brake_enable &&
        !cfg.parking_brake_enable;
    endproperty
    a_soft: assert property (p_soft) else $error("soft reset value wrong"); // RULE11 RULE6 RULE7

    // keeps everything but the reserved fields
    property p_restart;
        @(posedge clk) disable iff (!rst_n)
        (restart_reset && !soft_reset)
        |=>
        (state.brake == ($past(state.brake) & BCR_RESTART_KEEP));
    endproperty
    a_restart: assert property (p_restart) else $error("restart value wrong"); // RULE12

    // no reset and no write hit leaves the word alone
    property p_hold;
        @(posedge clk) disable iff (!rst_n)
        (!soft_reset && !restart_reset && !(req.wr && hit))
        |=>
        $stable(state.brake);
    endproperty
    a_hold: assert property (p_hold) else $error("register changed without cause"); // RULE13

    // first edge after release still shows the reset contents
    property p_por_value;
        @(posedge clk) disable iff (!rst_n)
        !$past(rst_n)
        |->
        (state.brake == BCR_BRAKE_RESET) &&
        (rsp == '0);
    endproperty
    a_por_value: assert property (p_por_value) else $error("power-on value wrong"); // RULE11

    // enables and blank select come up in their default levels
    property p_por_cfg;
        @(posedge clk) disable iff (!rst_n)
        !$past(rst_n)
        |->
        cfg.brake_blank_time_sel && cfg.overvoltage_brake_enable &&
        !cfg.parking_brake_enable && !cfg.slam_enable;
    endproperty
    a_por_cfg: assert property (p_por_cfg) else $error("power-on levels wrong"); // RULE5 RULE6 RULE7

    property p_soft_cfg;
        @(posedge clk) disable iff (!rst_n)
        soft_reset
        |=>
        !cfg.slam_enable && !cfg.slam_lowside1_off && !cfg.slam_lowside2_off && !cfg.slam_lowside3_off &&
        !cfg.brake_drain_source_threshold_sel && cfg.brake_blank_time_sel &&
        !cfg.parking_brake_enable && cfg.overvoltage_brake_enable &&
        (cfg.overvoltage_brake_threshold == '0);
    endproperty
    a_soft_cfg: assert property (p_soft_cfg) else $error("soft reset levels wrong"); // RULE1 RULE2 RULE3 RULE4 RULE9

    // every configuration bit sits inside the keep mask
    property p_restart_cfg;
        @(posedge clk) disable iff (!rst_n)
        (restart_reset && !soft_reset)
        |=>
        (cfg == $past(cfg));
    endproperty
    a_restart_cfg: assert property (p_restart_cfg) else $error("restart changed levels"); // RULE12

    property p_restart_low;
        @(posedge clk) disable iff (!rst_n)
        (restart_reset && !soft_reset)
        |=>
        (state.brake[BCR_RSV_LO_MSB:BCR_RSV_LO_LSB] == '0);
    endproperty
    a_restart_low: assert property (p_restart_low) else $error("restart left reserved bits"); // RULE12

    // upper bits never store, whatever the host sends
    property p_hi_ignored;
        @(posedge clk) disable iff (!rst_n)
        wr_take
        |=>
        ((state.brake & ~BCR_STORE_MASK) == '0);
    endproperty
    a_hi_ignored: assert property (p_hi_ignored) else $error("upper bits stored"); // RULE10

    property p_valid_follows;
        @(posedge clk) disable iff (!rst_n)
        (req.wr || req.rd)
        |=>
        rsp.valid;
    endproperty
    a_valid_follows: assert property (p_valid_follows) else $error("no response to request"); // RULE13

    // idle cycles leave a clean response
    property p_quiet;
        @(posedge clk) disable iff (!rst_n)
        !(req.wr || req.rd)
        |=>
        !rsp.valid && !rsp.hit &&
        (rsp.rdata == '0);
    endproperty
    a_quiet: assert property (p_quiet) else $error("response without request"); // RULE13

    property p_miss;
        @(posedge clk) disable iff (!rst_n)
        ((req.wr || req.rd) && !hit)
        |=>
        rsp.valid && !rsp.hit &&
        (rsp.rdata == '0);
    endproperty
    a_miss: assert property (p_miss) else $error("other address answered"); // RULE13

    property p_write_rdata;
        @(posedge clk) disable iff (!rst_n)
        (req.wr && !req.rd)
        |=>
        (rsp.rdata == '0);
    endproperty
    a_write_rdata: assert property (p_write_rdata) else $error("write returned data"); // RULE13

    // read and write together: old word back, new word stored
    property p_wr_rd_old;
        @(posedge clk) disable iff (!rst_n)
        (wr_take && req.rd)
        |=>
        (rsp.rdata == ($past(state.brake) & BCR_STORE_MASK));
    endproperty
    a_wr_rd_old: assert property (p_wr_rd_old) else $error("same-edge read wrong"); // RULE13

    property p_read_keeps;
        @(posedge clk) disable iff (!rst_n)
        (req.rd && !req.wr && !soft_reset && !restart_reset)
        |=>
        $stable(state.brake);
    endproperty
    a_read_keeps: assert property (p_read_keeps) else $error("read changed register"); // RULE13

    // main scenarios
    c_slam_on: cover property (@(posedge clk) disable iff (!rst_n)
        $rose(cfg.slam_enable));
    c_read_back: cover property (@(posedge clk) disable iff (!rst_n)
        req.wr && hit ##1 req.rd && hit);
    c_restart: cover property (@(posedge clk) disable iff (!rst_n)
        restart_reset && state.brake[BCR_RSV_LO_MSB:BCR_RSV_LO_LSB] != '0);
    c_soft: cover property (@(posedge clk) disable iff (!rst_n)
        soft_reset && state.brake != BCR_BRAKE_RESET);
    c_wr_rd_same: cover property (@(posedge clk) disable iff (!rst_n)
        req.wr && req.rd && hit);

endmodule // bcr_brake_reg

`default_nettype wire

// ==== rtl/bcr_pkg.sv ====
package bcr_pkg;

    localparam int BCR_DATA_W = 16;
    localparam int BCR_ADDR_W = 7;

    // register address on the serial register port
    localparam logic [BCR_ADDR_W-1:0] BCR_BRAKE_ADDR = 7'h1D;

    // field positions
    localparam int BCR_THRESH_LSB = 0;
    localparam int BCR_THRESH_MSB = 2;
    localparam int BCR_RSV_LO_LSB = 3;
    localparam int BCR_RSV_LO_MSB = 4;
    localparam int BCR_OV_EN_BIT = 5;
    localparam int BCR_PARK_EN_BIT = 6;
    localparam int BCR_BLANK_BIT = 7;
    localparam int BCR_VDS_BIT = 8;
    localparam int BCR_SLAM_BIT = 9;
    localparam int BCR_LS1_OFF_BIT = 10;
    localparam int BCR_LS2_OFF_BIT = 11;
    localparam int BCR_LS3_OFF_BIT = 12;

    // power-on / soft reset value
    localparam logic [BCR_DATA_W-1:0] BCR_BRAKE_RESET = 16'h00A0;
    // bits that hold state; bits 15:13 are not stored
    localparam logic [BCR_DATA_W-1:0] BCR_STORE_MASK = 16'h1FFF;
    // bits kept across a restart-type reset
    localparam logic [BCR_DATA_W-1:0] BCR_RESTART_KEEP = 16'h1FE7;

    // register port request, one cycle per access
    typedef struct packed {
        logic wr;
        logic rd;
        logic [BCR_ADDR_W-1:0] addr;
        logic [BCR_DATA_W-1:0] wdata;
    } bcr_req_t;

    typedef struct packed {
        logic valid;
        logic hit;
        logic [BCR_DATA_W-1:0] rdata;
    } bcr_rsp_t;

    // configuration levels driven into the brake and slam circuits
    typedef struct packed {
        logic slam_enable;
        logic slam_lowside1_off;
        logic slam_lowside2_off;
        logic slam_lowside3_off;
        logic brake_drain_source_threshold_sel;
        logic brake_blank_time_sel;
        logic parking_brake_enable;
        logic overvoltage_brake_enable;
        logic [2:0] overvoltage_brake_threshold;
    } bcr_cfg_t;

    typedef struct packed {
        logic [BCR_DATA_W-1:0] brake;
        bcr_rsp_t rsp;
    } bcr_state_t;

endpackage

// ==== verification/bcr_host.sv ====
`timescale 1ns/100ps
`default_nettype none
module bcr_host (
    input wire logic wr,
    input wire logic rd,
    input wire logic [6:0] addr,
    input wire logic [15:0] data,
    input wire logic rsv_ok,
    output var bcr_pkg::bcr_req_t req
);
    import bcr_pkg::*;
    // rsv_ok lets one scenario break the host rule on purpose
    always_comb begin
        req.wr = wr;
        req.rd = rd;
        req.addr = addr;
        req.wdata = rsv_ok ? data : (data & 16'hFFE7);
    end
endmodule // bcr_host
`default_nettype wire

// ==== verification/bcr_brake_reg_tb.sv ====
`timescale 1ns/100ps
`default_nettype none
module bcr_brake_reg_tb;
    import bcr_pkg::*;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic soft_reset = 1'b0;
    logic restart_reset = 1'b0;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic rsv_ok = 1'b0;
    logic [6:0] addr = 7'h00;
    logic [15:0] data = 16'h0000;
    logic [15:0] v;
    bcr_req_t req;
    bcr_rsp_t rsp;
    bcr_cfg_t cfg;
    int fail_count = 0;
    int checked = 0;
    int cycles = 0;
    always #2 clk = ~clk;
    bcr_host host (.wr(wr), .rd(rd), .addr(addr), .data(data), .rsv_ok(rsv_ok), .req(req));
    bcr_brake_reg uut (.clk(clk), .rst_n(rst_n), .soft_reset(soft_reset), .restart_reset(restart_reset),
        .req(req), .rsp(rsp), .cfg(cfg));
    task automatic chk_word(input logic [15:0] got, input logic [15:0] exp);
        checked++;
        if (got !== exp) begin
            fail_count++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic chk_cfg(input logic [15:0] r);
        logic [10:0] exp;
        exp = {r[9], r[10], r[11], r[12], r[8:5], r[2:0]};
        checked++;
        if (cfg !== exp) begin
            fail_count++;
            $display("mismatch at %0t: got %h expected %h", $time, cfg, exp);
        end
    endtask
    // request held one edge; response checked while it stands
    task automatic acc(input logic w, input logic [6:0] a, input logic [15:0] d, input logic h,
        input logic [15:0] exp);
        wr = w;
        rd = ~w;
        addr = a;
        data = d;
        @(posedge clk);
        #1;
        chk_word({14'h0000, rsp.valid, rsp.hit}, {14'h0000, 1'b1, h});
        chk_word(rsp.rdata, exp);
    endtask
    task automatic idle;
        wr = 1'b0;
        rd = 1'b0;
    endtask
    task automatic final_report;
        if (fail_count == 0 && checked > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    always @(posedge clk) begin
        cycles++;
        if (cycles == 1000) begin
            fail_count++;
            final_report();
        end
    end
    initial begin
        repeat (3) @(posedge clk);
        #1;
        rst_n = 1'b1;
        acc(1'b0, BCR_BRAKE_ADDR, 16'h0000, 1'b1, BCR_BRAKE_RESET);
        chk_cfg(16'h00A0);
        acc(1'b1, BCR_BRAKE_ADDR, 16'hFFFF, 1'b1, 16'h0000);
        chk_cfg(16'h1FE7);
        acc(1'b0, BCR_BRAKE_ADDR, 16'h0000, 1'b1, 16'h1FE7);
        for (int i = 0; i < 8; i++) begin
            v = {3'b000, ~i[0], i[1], i[2], i[0], ~i[1], i[2], ~i[2], i[0], 2'b00, i[2:0]};
            acc(1'b1, BCR_BRAKE_ADDR, v, 1'b1, 16'h0000);
            chk_cfg(v);
        end
        acc(1'b1, 7'h1C, 16'h1FFF, 1'b0, 16'h0000);
        acc(1'b0, 7'h1C, 16'h0000, 1'b0, 16'h0000);
        acc(1'b0, BCR_BRAKE_ADDR, 16'h0000, 1'b1, v);
        rsv_ok = 1'b1;
        acc(1'b1, BCR_BRAKE_ADDR, 16'hFFFF, 1'b1, 16'h0000);
        acc(1'b0, BCR_BRAKE_ADDR, 16'h0000, 1'b1, 16'h1FFF);
        idle();
        restart_reset = 1'b1;
        @(posedge clk);
        #1;
        restart_reset = 1'b0;
        chk_word({14'h0000, rsp.valid, rsp.hit}, 16'h0000);
        acc(1'b0, BCR_BRAKE_ADDR, 16'h0000, 1'b1, 16'h1FE7);
        chk_cfg(16'h1FE7);
        idle();
        soft_reset = 1'b1;
        @(posedge clk);
        #1;
        soft_reset = 1'b0;
        acc(1'b0, BCR_BRAKE_ADDR, 16'h0000, 1'b1, 16'h00A0);
        chk_cfg(16'h00A0);
        idle();
        final_report();
    end
endmodule // bcr_brake_reg_tb
`default_nettype wire
